/* bbie_pkg.sv */
/*
 Shared types and constants for the byte and bit instruction datapath.
 Assumes a single 25 MHz clock and a synchronous active-high reset.
*/
package bbie_pkg;

   // Clock and instruction cycle timing
   localparam int          CLK_PERIOD_NS    = 40;
   localparam int          PHASES_PER_CYCLE = 4;
   localparam int          INS_CYCLE_NS     = PHASES_PER_CYCLE * CLK_PERIOD_NS;
   localparam logic [1:0]  FIRST_PHASE      = 2'h0;
   localparam logic [1:0]  LAST_PHASE       = 2'(PHASES_PER_CYCLE - 1);

   // Data widths and register file geometry
   localparam int          DATA_W           = 8;
   localparam int          FADDR_W          = 7;
   localparam int          RF_DEPTH         = 128;
   localparam int          BUS_ADDR_W       = 8;

   // Bus map
   localparam logic [7:0]  RF_BASE_ADDR     = 8'h00;
   localparam logic [7:0]  W_ADDR           = 8'h80;
   localparam logic [7:0]  STATUS_ADDR      = 8'h81;
   localparam int          ZERO_BIT         = 2;
   localparam int          HALF_CARRY_BIT   = 1;
   localparam int          CARRY_BIT        = 0;

   // Reset values and bit mask
   localparam logic [7:0]  W_RESET          = 8'h00;
   localparam logic [7:0]  ZERO_BYTE        = 8'h00;
   localparam logic [7:0]  ONE_BIT_MASK     = 8'h01;

   typedef enum logic [3:0] {
      idle_slot,
      add_literal_op,
      and_literal_op,
      add_register_op,
      and_register_op,
      bit_clear_op,
      bit_set_op,
      test_skip_if_one_op,
      register_zero_op
   } bbie_op_type;

   typedef struct packed {
      bbie_op_type         op;
      logic [7:0]          lit;
      logic [6:0]          faddr;
      logic [2:0]          bsel;
      logic                dest;
   } bbie_ins_type;

   localparam bbie_ins_type IDLE_INS = '{op: idle_slot, lit: 8'h00,
                                         faddr: 7'h00, bsel: 3'h0,
                                         dest: 1'b0};

   typedef struct packed {
      logic                zero_flag;
      logic                half_carry_flag;
      logic                carry_flag;
   } bbie_flags_type;

   typedef struct packed {
      logic [7:0]          res;
      logic                c;
      logic                dc;
      logic                z;
      logic                wr_w;
      logic                wr_f;
      logic                upd_z;
      logic                upd_cdc;
      logic                skip;
   } bbie_alu_type;

   typedef struct packed {
      logic [1:0]          phase;
      logic                take;
      logic                done;
      logic                idle;
      bbie_ins_type        ins;
      logic [7:0]          w;
      bbie_flags_type      flags;
      logic [7:0]          rdata;
   } bbie_state_type;

   localparam bbie_state_type STATE_RESET = '{phase: FIRST_PHASE,
      take: 1'b0, done: 1'b0, idle: 1'b0, ins: IDLE_INS, w: W_RESET,
      flags: 3'h0, rdata: ZERO_BYTE};

endpackage : bbie_pkg

/* bbie_alu.sv */
/*
 Combinational arithmetic and bit unit for one instruction.
 Assumes operands are stable for the whole instruction cycle.
*/
`timescale 1ns/1ps
module bbie_alu (
   input  wire bbie_pkg::bbie_ins_type i_ins,
   input  wire logic [7:0]             i_w,
   input  wire logic [7:0]             i_f,
   output bbie_pkg::bbie_alu_type      o_res
);

   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] operand;
   logic [7:0] mask;

   always_comb begin
      operand = (i_ins.op == bbie_pkg::add_literal_op ||
                 i_ins.op == bbie_pkg::and_literal_op) ? i_ins.lit : i_f;
      sum9    = {1'b0, i_w} + {1'b0, operand};
      sum5    = {1'b0, i_w[3:0]} + {1'b0, operand[3:0]};
      mask    = bbie_pkg::ONE_BIT_MASK << i_ins.bsel;
      o_res   = '0;
      case (i_ins.op)
         bbie_pkg::add_literal_op: begin
            o_res.res     = sum9[7:0];
            o_res.wr_w    = 1'b1;
            o_res.upd_z   = 1'b1;
            o_res.upd_cdc = 1'b1;
         end
         bbie_pkg::and_literal_op: begin
            o_res.res   = i_w & operand;
            o_res.wr_w  = 1'b1;
            o_res.upd_z = 1'b1;
         end
         bbie_pkg::add_register_op: begin
            o_res.res     = sum9[7:0];
            o_res.wr_w    = ~i_ins.dest;
            o_res.wr_f    = i_ins.dest;
            o_res.upd_z   = 1'b1;
            o_res.upd_cdc = 1'b1;
         end
         bbie_pkg::and_register_op: begin
            o_res.res   = i_w & operand;
            o_res.wr_w  = ~i_ins.dest;
            o_res.wr_f  = i_ins.dest;
            o_res.upd_z = 1'b1;
         end
         bbie_pkg::bit_clear_op: begin
            o_res.res  = i_f & ~mask;
            o_res.wr_f = 1'b1;
         end
         bbie_pkg::bit_set_op: begin
            o_res.res  = i_f | mask;
            o_res.wr_f = 1'b1;
         end
         bbie_pkg::test_skip_if_one_op: begin
            o_res.skip = i_f[i_ins.bsel];
         end
         bbie_pkg::register_zero_op: begin
            o_res.res   = bbie_pkg::ZERO_BYTE;
            o_res.wr_f  = 1'b1;
            o_res.upd_z = 1'b1;
         end
         default: begin
            o_res.res = bbie_pkg::ZERO_BYTE;
         end
      endcase
      o_res.c  = sum9[8];
      o_res.dc = sum5[4];
      o_res.z  = (o_res.res == bbie_pkg::ZERO_BYTE);
   end

endmodule : bbie_alu

/* bbie_regfile.sv */
/*
 File register storage, one write port and two read ports.
 Assumes the writer resolves port conflicts before this module.
*/
`timescale 1ns/1ps
module bbie_regfile #(
   parameter int DEPTH  = 128,
   parameter int WIDTH  = 8,
   parameter int ADDR_W = 7
) (
   input  wire logic              i_clk,
   input  wire logic              i_we,
   input  wire logic [ADDR_W-1:0] i_waddr,
   input  wire logic [WIDTH-1:0]  i_wdata,
   input  wire logic [ADDR_W-1:0] i_raddr_a,
   output logic      [WIDTH-1:0]  o_rdata_a,
   input  wire logic [ADDR_W-1:0] i_raddr_b,
   output logic      [WIDTH-1:0]  o_rdata_b
);

   // No reset: contents are undefined until software or code writes them
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   assign o_rdata_a = mem[i_raddr_a];
   assign o_rdata_b = mem[i_raddr_b];

endmodule : bbie_regfile

/* byte_bit_instruction_exec.sv */
/*
 Byte and bit instruction execution datapath with accumulator and flags.
 Assumes the core presents an instruction when o_ins_take is high and a
 plain register port that strobes reads and writes for one cycle.
*/
`timescale 1ns/1ps
// Contract
// - Add literal to accumulator, result to accumulator, update C, DC, Z.
// - AND literal with accumulator into accumulator, update only Z.
// - AND accumulator with register, route by destination bit, only Z.
// - Add accumulator and register, route by destination bit, C DC Z.
// - Bit clear forces selected register bit to zero, no flags.
// - Bit set forces selected register bit to one, no flags.
// - Test bit zero: next instruction runs, one cycle, no flags.
// - Test bit one: fetched instruction becomes idle slot, two cycles.
// - Register clear writes zero to register and sets zero flag.
// - Instruction cycle is four clocks; non-skip instructions take one.
module byte_bit_instruction_exec (
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   input  wire logic                   i_ins_valid,
   input  wire bbie_pkg::bbie_ins_type i_ins,
   input  wire logic [7:0]             i_bus_addr,
   input  wire logic [7:0]             i_bus_wdata,
   input  wire logic                   i_bus_we,
   input  wire logic                   i_bus_re,
   output logic      [7:0]             o_bus_rdata,
   output logic                        o_ins_take,
   output logic                        o_cycle_done,
   output logic                        o_skip_idle,
   output logic      [7:0]             o_w,
   output bbie_pkg::bbie_flags_type    o_flags
);

   bbie_pkg::bbie_state_type st_r;
   bbie_pkg::bbie_state_type st_nxt;
   bbie_pkg::bbie_alu_type   alu;
   logic                     commit;
   logic [7:0]               f_rd;
   logic [7:0]               bus_rd;
   logic                     rf_we;
   logic [6:0]               rf_waddr;
   logic [7:0]               rf_wdata;
   logic                     exec_wr_f;
   logic                     bus_wr_f;

   function automatic logic is_rf_addr(input logic [7:0] addr);
      return addr[7] == bbie_pkg::RF_BASE_ADDR[7];
   endfunction : is_rf_addr

   bbie_alu u_alu (
      .i_ins (st_r.ins),
      .i_w   (st_r.w),
      .i_f   (f_rd),
      .o_res (alu)
   );

   bbie_regfile #(
      .DEPTH  (bbie_pkg::RF_DEPTH),
      .WIDTH  (bbie_pkg::DATA_W),
      .ADDR_W (bbie_pkg::FADDR_W)
   ) u_regfile (
      .i_clk     (i_clk),
      .i_we      (rf_we),
      .i_waddr   (rf_waddr),
      .i_wdata   (rf_wdata),
      .i_raddr_a (st_r.ins.faddr),
      .o_rdata_a (f_rd),
      .i_raddr_b (i_bus_addr[6:0]),
      .o_rdata_b (bus_rd)
   );

   // Instruction results commit on the last phase of the cycle
   assign commit    = (st_r.phase == bbie_pkg::LAST_PHASE);
   assign exec_wr_f = commit && alu.wr_f;
   assign bus_wr_f  = i_bus_we && is_rf_addr(i_bus_addr);

   // Execution owns the write port on collision; a coincident bus write is lost
   always_comb begin
      rf_we    = exec_wr_f || bus_wr_f;
      rf_waddr = exec_wr_f ? st_r.ins.faddr : i_bus_addr[6:0];
      rf_wdata = exec_wr_f ? alu.res : i_bus_wdata;
   end

   always_comb begin
      st_nxt       = st_r;
      st_nxt.phase = st_r.phase + 2'h1;
      st_nxt.take  = (st_nxt.phase == bbie_pkg::LAST_PHASE);
      st_nxt.done  = commit;
      st_nxt.rdata = bbie_pkg::ZERO_BYTE;
      if (i_bus_we && i_bus_addr == bbie_pkg::W_ADDR &&
          !(commit && alu.wr_w)) begin
         st_nxt.w = i_bus_wdata;
      end
      if (i_bus_we && i_bus_addr == bbie_pkg::STATUS_ADDR &&
          !(commit && (alu.upd_z || alu.upd_cdc))) begin
         st_nxt.flags.zero_flag       = i_bus_wdata[bbie_pkg::ZERO_BIT];
         st_nxt.flags.half_carry_flag =
            i_bus_wdata[bbie_pkg::HALF_CARRY_BIT];
         st_nxt.flags.carry_flag      = i_bus_wdata[bbie_pkg::CARRY_BIT];
      end
      if (commit) begin
         if (alu.wr_w) begin
            st_nxt.w = alu.res;
         end
         if (alu.upd_z) begin
            st_nxt.flags.zero_flag = alu.z;
         end
         if (alu.upd_cdc) begin
            st_nxt.flags.carry_flag      = alu.c;
            st_nxt.flags.half_carry_flag = alu.dc;
         end
         // The fetched word is dropped, so a taken test spends two cycles
         st_nxt.idle = alu.skip;
         if (alu.skip || !i_ins_valid) begin
            st_nxt.ins = bbie_pkg::IDLE_INS;
         end else begin
            st_nxt.ins = i_ins;
         end
      end
      if (i_bus_re) begin
         if (is_rf_addr(i_bus_addr)) begin
            st_nxt.rdata = bus_rd;
         end else if (i_bus_addr == bbie_pkg::W_ADDR) begin
            st_nxt.rdata = st_r.w;
         end else if (i_bus_addr == bbie_pkg::STATUS_ADDR) begin
            st_nxt.rdata = {5'h00, st_r.flags};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_r <= bbie_pkg::STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_bus_rdata  = st_r.rdata;
   assign o_ins_take   = st_r.take;
   assign o_cycle_done = st_r.done;
   assign o_skip_idle  = st_r.idle;
   assign o_w          = st_r.w;
   assign o_flags      = st_r.flags;

   // Checking helpers
   logic [8:0] chk_sum9;
   logic [4:0] chk_sum5;
   logic [7:0] chk_and;
   logic       bus_flag_wr;

   assign chk_sum9    = {1'b0, st_r.w} + {1'b0, f_rd};
   assign chk_sum5    = {1'b0, st_r.w[3:0]} + {1'b0, f_rd[3:0]};
   assign chk_and     = st_r.w & f_rd;
   assign bus_flag_wr = i_bus_we && i_bus_addr == bbie_pkg::STATUS_ADDR;

   a_add_lit_sum: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::add_literal_op |=>
      st_r.w == 8'($past(st_r.w) + $past(st_r.ins.lit)))
      else $error("add literal result wrong");

   a_and_lit_flags: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::and_literal_op && !bus_flag_wr |=>
      st_r.w == ($past(st_r.w) & $past(st_r.ins.lit)) &&
      $stable(st_r.flags.carry_flag) && $stable(st_r.flags.half_carry_flag))
      else $error("and literal result or flags wrong");

   a_and_reg_route: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::and_register_op |->
      (st_r.ins.dest ? (rf_we && rf_wdata == chk_and) : !exec_wr_f) ##1
      st_r.flags.zero_flag == ($past(chk_and) == 8'h00))
      else $error("and register routing wrong");

   a_add_reg_carry: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::add_register_op && !bus_flag_wr |=>
      st_r.flags.carry_flag == $past(chk_sum9[8]) &&
      st_r.flags.half_carry_flag == $past(chk_sum5[4]))
      else $error("add register carry wrong");

   a_bit_clear_wr: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::bit_clear_op |->
      rf_we && rf_wdata == (f_rd & ~(8'h01 << st_r.ins.bsel)) &&
      !alu.upd_z && !alu.upd_cdc)
      else $error("bit clear write wrong");

   a_bit_set_wr: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::bit_set_op |->
      rf_we && rf_wdata == (f_rd | (8'h01 << st_r.ins.bsel)))
      else $error("bit set write wrong");

   a_test_no_skip: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::test_skip_if_one_op &&
      !f_rd[st_r.ins.bsel] && i_ins_valid && !bus_flag_wr |=>
      st_r.ins == $past(i_ins) && !st_r.idle && $stable(st_r.flags))
      else $error("test without skip wrong");

   a_test_skip_idle: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::test_skip_if_one_op &&
      f_rd[st_r.ins.bsel] |=>
      st_r.idle && st_r.ins.op == bbie_pkg::idle_slot ##4 st_r.done)
      else $error("taken skip did not insert idle slot");

   a_reg_zero_z: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && st_r.ins.op == bbie_pkg::register_zero_op |->
      rf_we && rf_wdata == 8'h00 ##1 st_r.flags.zero_flag)
      else $error("register clear wrong");

   a_cycle_four: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      st_r.take |=> !st_r.take [*3] ##1 st_r.take)
      else $error("instruction cycle not four clocks");

   a_zero_flag: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      commit && alu.upd_z && !bus_flag_wr |=>
      st_r.flags.zero_flag == ($past(alu.res) == 8'h00))
      else $error("zero flag wrong");

endmodule : byte_bit_instruction_exec

/* bbie_tb.sv */
/*
 Self-checking testbench for the byte and bit instruction datapath.
 Assumes the core cadence of one instruction take every four clocks and
 a register port with read data in the cycle after the read strobe.
*/
`timescale 1ns/1ps
module testbench;

   typedef struct packed {
      bbie_pkg::bbie_op_type op;
      logic [7:0]            lit;
      logic [6:0]            fa;
      logic [2:0]            b;
      logic                  d;
      logic [7:0]            w0;
      logic [7:0]            f0;
      logic [2:0]            s0;
      logic [7:0]            ew;
      logic [7:0]            ef;
      logic [2:0]            es;
   } bbie_row_type;

   logic                     i_clk;
   logic                     i_sys_rst   = 1'b1;
   logic                     i_ins_valid = 1'b0;
   bbie_pkg::bbie_ins_type   i_ins       = bbie_pkg::IDLE_INS;
   logic [7:0]               i_bus_addr  = 8'h00;
   logic [7:0]               i_bus_wdata = 8'h00;
   logic                     i_bus_we    = 1'b0;
   logic                     i_bus_re    = 1'b0;
   logic [7:0]               o_bus_rdata;
   logic                     o_ins_take;
   logic                     o_cycle_done;
   logic                     o_skip_idle;
   logic [7:0]               o_w;
   bbie_pkg::bbie_flags_type o_flags;
   int                       errors      = 0;
   int                       compares    = 0;
   logic [7:0]               got;
   bbie_row_type             r;

   // Flags are {zero, half carry, carry}; rows hold start and end values
   bbie_row_type rows [0:17] = '{
      '{bbie_pkg::add_literal_op, 8'h01, 7'h05, 3'h0, 1'b0,
        8'h0F, 8'h33, 3'h0, 8'h10, 8'h33, 3'h2},
      '{bbie_pkg::add_literal_op, 8'h01, 7'h05, 3'h0, 1'b0,
        8'hFF, 8'h33, 3'h0, 8'h00, 8'h33, 3'h7},
      '{bbie_pkg::add_literal_op, 8'h80, 7'h05, 3'h0, 1'b0,
        8'h80, 8'h33, 3'h2, 8'h00, 8'h33, 3'h5},
      '{bbie_pkg::add_literal_op, 8'hFF, 7'h05, 3'h0, 1'b0,
        8'h12, 8'h33, 3'h4, 8'h11, 8'h33, 3'h3},
      '{bbie_pkg::and_literal_op, 8'h0F, 7'h05, 3'h0, 1'b0,
        8'hF0, 8'h33, 3'h3, 8'h00, 8'h33, 3'h7},
      '{bbie_pkg::and_literal_op, 8'h3C, 7'h05, 3'h0, 1'b0,
        8'hFF, 8'h33, 3'h7, 8'h3C, 8'h33, 3'h3},
      '{bbie_pkg::and_register_op, 8'h00, 7'h00, 3'h0, 1'b0,
        8'hAA, 8'h0F, 3'h7, 8'h0A, 8'h0F, 3'h3},
      '{bbie_pkg::and_register_op, 8'h00, 7'h7F, 3'h0, 1'b1,
        8'h55, 8'hAA, 3'h0, 8'h55, 8'h00, 3'h4},
      '{bbie_pkg::add_register_op, 8'h00, 7'h10, 3'h0, 1'b0,
        8'h08, 8'h08, 3'h5, 8'h10, 8'h08, 3'h2},
      '{bbie_pkg::add_register_op, 8'h00, 7'h7F, 3'h0, 1'b1,
        8'hF0, 8'h20, 3'h0, 8'hF0, 8'h10, 3'h1},
      '{bbie_pkg::add_register_op, 8'h00, 7'h01, 3'h0, 1'b1,
        8'h01, 8'hFF, 3'h0, 8'h01, 8'h00, 3'h7},
      '{bbie_pkg::bit_clear_op, 8'h00, 7'h22, 3'h7, 1'b0,
        8'h11, 8'hFF, 3'h5, 8'h11, 8'h7F, 3'h5},
      '{bbie_pkg::bit_clear_op, 8'h00, 7'h22, 3'h0, 1'b0,
        8'h11, 8'h01, 3'h2, 8'h11, 8'h00, 3'h2},
      '{bbie_pkg::bit_set_op, 8'h00, 7'h23, 3'h0, 1'b0,
        8'h11, 8'h00, 3'h0, 8'h11, 8'h01, 3'h0},
      '{bbie_pkg::bit_set_op, 8'h00, 7'h23, 3'h7, 1'b0,
        8'h11, 8'h7F, 3'h7, 8'h11, 8'hFF, 3'h7},
      '{bbie_pkg::register_zero_op, 8'h00, 7'h40, 3'h0, 1'b0,
        8'h11, 8'h5A, 3'h0, 8'h11, 8'h00, 3'h4},
      '{bbie_pkg::register_zero_op, 8'h00, 7'h41, 3'h0, 1'b0,
        8'h11, 8'h00, 3'h3, 8'h11, 8'h00, 3'h7},
      '{bbie_pkg::test_skip_if_one_op, 8'h00, 7'h42, 3'h4, 1'b0,
        8'h11, 8'hEF, 3'h6, 8'h11, 8'hEF, 3'h6}
   };

   byte_bit_instruction_exec DUT (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_ins_valid  (i_ins_valid),
      .i_ins        (i_ins),
      .i_bus_addr   (i_bus_addr),
      .i_bus_wdata  (i_bus_wdata),
      .i_bus_we     (i_bus_we),
      .i_bus_re     (i_bus_re),
      .o_bus_rdata  (o_bus_rdata),
      .o_ins_take   (o_ins_take),
      .o_cycle_done (o_cycle_done),
      .o_skip_idle  (o_skip_idle),
      .o_w          (o_w),
      .o_flags      (o_flags)
   );

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   task automatic final_report;
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // A gap cycle after each strobe keeps one assignment per time step
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      i_bus_addr  <= a;
      i_bus_wdata <= d;
      i_bus_we    <= 1'b1;
      @(posedge i_clk);
      i_bus_we    <= 1'b0;
      @(posedge i_clk);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      i_bus_addr <= a;
      i_bus_re   <= 1'b1;
      @(posedge i_clk);
      i_bus_re   <= 1'b0;
      #1;
      d = o_bus_rdata;
      @(posedge i_clk);
   endtask : bus_rd

   // Returns in the time step of the edge that took the instruction
   // Take is looked at after it settles, then the taking edge is awaited
   task automatic issue(input bbie_pkg::bbie_ins_type ins);
      int n;
      n = 0;
      i_ins       <= ins;
      i_ins_valid <= 1'b1;
      #1;
      while (o_ins_take !== 1'b1 && n < 8) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk("take seen", 8'h01, {7'h00, o_ins_take});
      @(posedge i_clk);
   endtask : issue

   // Test of a bit, then two literal adds offered back to back
   task automatic skip_case(input logic b1);
      bus_wr(bbie_pkg::W_ADDR, 8'h10);
      bus_wr(bbie_pkg::STATUS_ADDR, 8'h00);
      bus_wr(8'h30, b1 ? 8'h08 : 8'hF7);
      issue('{bbie_pkg::test_skip_if_one_op, 8'h00, 7'h30, 3'h3, 1'b0});
      issue('{bbie_pkg::add_literal_op, 8'h01, 7'h00, 3'h0, 1'b0});
      i_ins <= '{bbie_pkg::add_literal_op, 8'h02, 7'h00, 3'h0, 1'b0};
      for (int k = 0; k < 4; k++) begin
         #1;
         chk("skip idle", {7'h00, b1}, {7'h00, o_skip_idle});
         @(posedge i_clk);
      end
      i_ins_valid <= 1'b0;
      #1;
      chk("skip over", 8'h00, {7'h00, o_skip_idle});
      repeat (4) @(posedge i_clk);
      #1;
      chk("w after test", b1 ? 8'h12 : 8'h13, o_w);
      chk("flags after test", 8'h00, {5'h00, o_flags});
   endtask : skip_case

   // Whole run is well under a thousand clocks
   initial begin
      repeat (20000) @(posedge i_clk);
      errors++;
      final_report();
   end

   initial begin
      repeat (20) @(posedge i_clk);
      #1;
      chk("reset w", 8'h00, o_w);
      chk("reset flags", 8'h00, {5'h00, o_flags});
      chk("reset take", 8'h00, {7'h00, o_ins_take});
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      for (int i = 0; i < 18; i++) begin
         r = rows[i];
         bus_wr(bbie_pkg::W_ADDR, r.w0);
         bus_wr(bbie_pkg::STATUS_ADDR, {5'h00, r.s0});
         bus_wr({1'b0, r.fa}, r.f0);
         issue('{r.op, r.lit, r.fa, r.b, r.d});
         i_ins_valid <= 1'b0;
         repeat (3) @(posedge i_clk);
         #1;
         chk("early w", r.w0, o_w);
         chk("early done", 8'h00, {7'h00, o_cycle_done});
         @(posedge i_clk);
         #1;
         chk("done", 8'h01, {7'h00, o_cycle_done});
         chk("w", r.ew, o_w);
         chk("flags", {5'h00, r.es}, {5'h00, o_flags});
         bus_rd({1'b0, r.fa}, got);
         chk("register", r.ef, got);
         bus_rd(bbie_pkg::STATUS_ADDR, got);
         chk("status", {5'h00, r.es}, got);
      end
      // Unmapped place must neither store nor disturb the accumulator
      bus_wr(8'h82, 8'hA5);
      bus_rd(8'h82, got);
      chk("unmapped", 8'h00, got);
      bus_rd(bbie_pkg::W_ADDR, got);
      chk("w read", 8'h11, got);
      skip_case(1'b0);
      skip_case(1'b1);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      chk("rerun w", 8'h00, o_w);
      chk("rerun flags", 8'h00, {5'h00, o_flags});
      chk("rerun skip", 8'h00, {7'h00, o_skip_idle});
      final_report();
   end

endmodule : testbench
